// file: design/adc_seq_consts.vh
// Register map, field positions, reset values and timing counts of the converter sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register indices on the 3-bit register port
`define REG_CTRL_ZERO      3'h0
`define REG_CTRL_ONE       3'h1
`define REG_CTRL_TWO       3'h2
`define REG_RESULT_HIGH    3'h3
`define REG_RESULT_LOW     3'h4
`define REG_STATUS         3'h5
`define REG_PORT_LOW       3'h6
`define REG_PORT_HIGH      3'h7

// converter_control_zero fields
`define CTRL0_ON_BIT       0
`define CTRL0_GO_BIT       1
`define CTRL0_CHS_LSB      2
`define CTRL0_CHS_MSB      5

// converter_control_one field (pin_analog_cfg)
`define CTRL1_PCFG_LSB     0
`define CTRL1_PCFG_MSB     3

// converter_control_two fields
`define CTRL2_ADCS_LSB     0
`define CTRL2_ADCS_MSB     2
`define CTRL2_ACQT_LSB     3
`define CTRL2_ACQT_MSB     5

// Status register field
`define STATUS_DONE_BIT    0

// Reset values
`define CHS_RST            4'h0
`define ACQT_RST           3'h0
`define ADCS_RST           3'h0
`define PCFG_RST_ANALOG    4'h0
`define PCFG_RST_DIGITAL   4'h7
`define RESULT_RST         8'h00
`define RD_DATA_RST        8'h00

// Conversion clock select codes and the bit period in oscillator periods
`define ADCS_DIV2          3'h0
`define ADCS_DIV4          3'h4
`define ADCS_DIV8          3'h1
`define ADCS_DIV16         3'h5
`define ADCS_DIV32         3'h2
`define ADCS_DIV64         3'h6
`define ADCS_RC_LOW        2'h3
`define TAD_OSC_2          7'h02
`define TAD_OSC_4          7'h04
`define TAD_OSC_8          7'h08
`define TAD_OSC_16         7'h10
`define TAD_OSC_32         7'h20
`define TAD_OSC_64         7'h40

// Timing: instruction cycle is four oscillator periods
`define TCY_OSC            4
`define RC_START_DELAY_TCY 1
`define RESTART_WAIT_TCY   2
`define RC_DELAY_CYCLES    (`RC_START_DELAY_TCY * `TCY_OSC)
`define RESTART_WAIT_CYCLES (`RESTART_WAIT_TCY * `TCY_OSC)
`define CONV_TAD           13
`define RESULT_BITS        12
`define ANALOG_PINS        13

`endif

// file: design/tad_tick_gen.v
// Bit period tick generator: oscillator divider or internal RC clock tick
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module tad_tick_gen #(
	parameter CNT_W = 7
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             sys_rst,
	// Control
	input  wire             run,
	input  wire [2:0]       clk_sel,
	input  wire             rc_tick,
	// One-cycle pulse at the end of each bit period
	output wire             tick
);

	reg  [CNT_W-1:0] cnt_q;
	reg  [CNT_W-1:0] period;
	wire             rc_sel;
	wire             div_end;

	assign rc_sel  = (clk_sel[1:0] == `ADCS_RC_LOW);

	always @* begin
		case (clk_sel)
			`ADCS_DIV2:  period = `TAD_OSC_2;
			`ADCS_DIV4:  period = `TAD_OSC_4;
			`ADCS_DIV8:  period = `TAD_OSC_8;
			`ADCS_DIV16: period = `TAD_OSC_16;
			`ADCS_DIV32: period = `TAD_OSC_32;
			`ADCS_DIV64: period = `TAD_OSC_64;
			default:     period = `TAD_OSC_2;
		endcase
	end

	assign div_end = (cnt_q == period - {{(CNT_W-1){1'b0}}, 1'b1});
	// Counter restarts whenever the sequencer is idle so the first period is whole
	assign tick    = run & (rc_sel ? rc_tick : div_end);

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= {CNT_W{1'b0}};
		end else if (!run || rc_sel || div_end) begin
			cnt_q <= {CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule // tad_tick_gen

// file: design/adc_acquire_convert_sequencer.v
// Acquisition and successive-approximation conversion sequencer with its register port
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

// Contract
// - Hold capacitor is disconnected from the pin when conversion begins.
// - Nonzero acquisition field: sample for the bit periods the code selects, then convert.
// - Acquisition codes map to 0,2,4,6,8,12,16,20 bit periods.
// - Acquisition field zero: start flag stops sampling and converts at once.
// - On completion clear start flag, set done flag, resume sampling.
// - No status separates acquisition from conversion; start flag stays set.
// - A conversion lasts exactly 13 bit periods.
// - Clock field picks 2,4,8,16,32,64 oscillator periods or internal RC.
// - RC clock with zero acquisition delays conversion start one instruction cycle.
// - Clearing start mid-conversion aborts; results keep their previous value.
// - After completion or abort wait 2 instruction cycles, then sample again.
// - Sequence runs whatever the channel select and pin directions.
// - Port reads give zero on analog pins; digital pins stay convertible.
// - Pin analog field resets to 0000 or 0111 from the strap.
// - Start flag is bit 1 of control zero, enable in same register.
// - Reset clears registers, turns converter off, aborts conversion.
module adc_acquire_convert_sequencer (
	// Clock and reset
	input  wire                     sys_clk,
	input  wire                     sys_rst,
	// Register port
	input  wire [2:0]               addr,
	input  wire [7:0]               wr_data,
	input  wire                     wr_stb,
	input  wire                     rd_stb,
	output wire [7:0]               rd_data,
	// Configuration strap and internal RC clock tick
	input  wire                     portb_analog_default,
	input  wire                     rc_tick,
	// Analog front end
	input  wire                     comp_in,
	input  wire [`ANALOG_PINS-1:0]  port_pins_in,
	output wire                     hold_capacitor_connect,
	output wire [`RESULT_BITS-1:0]  dac_code,
	output wire [3:0]               channel_sel,
	output wire                     converter_on,
	output wire                     conv_done_irq_flag
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ACQ   = 3'h1;
	localparam [2:0] ST_RCDLY = 3'h2;
	localparam [2:0] ST_CONV  = 3'h3;
	localparam [2:0] ST_WAIT  = 3'h4;

	localparam integer CONV_LAST_N  = `CONV_TAD - 1;
	localparam integer RCDLY_LAST_N = `RC_DELAY_CYCLES - 1;
	localparam integer WAIT_LAST_N  = `RESTART_WAIT_CYCLES - 1;
	// All phase counts stay below 32, so five bits carry them whole
	localparam [4:0] CONV_LAST   = CONV_LAST_N[4:0];
	localparam [4:0] RCDLY_LAST  = RCDLY_LAST_N[4:0];
	localparam [4:0] WAIT_LAST   = WAIT_LAST_N[4:0];
	localparam [11:0] TRIAL_MSB  = 12'h800;

	reg  [2:0]               state_q;
	reg  [4:0]               cnt_q;
	reg                      on_q;
	reg                      go_q;
	reg  [3:0]               chs_q;
	reg  [3:0]               pcfg_q;
	reg                      cfg_loaded_q;
	reg  [2:0]               acqt_q;
	reg  [2:0]               adcs_q;
	reg  [7:0]               res_high_q;
	reg  [7:0]               res_low_q;
	reg                      done_q;
	reg  [`RESULT_BITS-1:0]  sar_q;
	reg  [`RESULT_BITS-1:0]  trial_q;
	reg  [7:0]               rd_data_q;

	reg  [4:0]               acq_len;
	reg  [`ANALOG_PINS-1:0]  analog_mask;
	reg  [4:0]               analog_count;
	reg  [7:0]               rd_d;
	integer                  i;

	wire ctrl0_wr;
	wire ctrl1_wr;
	wire ctrl2_wr;
	wire busy;
	wire abort;
	wire tad_run;
	wire tick;
	wire rc_sel;
	wire conv_end;
	wire [`ANALOG_PINS-1:0] port_read;

	assign ctrl0_wr = wr_stb & (addr == `REG_CTRL_ZERO);
	assign ctrl1_wr = wr_stb & (addr == `REG_CTRL_ONE);
	assign ctrl2_wr = wr_stb & (addr == `REG_CTRL_TWO);
	assign rc_sel   = (adcs_q[1:0] == `ADCS_RC_LOW);
	assign busy     = (state_q == ST_ACQ) | (state_q == ST_RCDLY) | (state_q == ST_CONV);
	// Clearing start or turning the converter off mid-sequence aborts it
	assign abort    = busy & ctrl0_wr & (~wr_data[`CTRL0_GO_BIT] | ~wr_data[`CTRL0_ON_BIT]);
	assign tad_run  = (state_q == ST_ACQ) | (state_q == ST_CONV);
	assign conv_end = (state_q == ST_CONV) & tick & (cnt_q == CONV_LAST) & ~abort;

	// Acquisition length in bit periods
	always @* begin
		case (acqt_q)
			3'h0:    acq_len = 5'd0;
			3'h1:    acq_len = 5'd2;
			3'h2:    acq_len = 5'd4;
			3'h3:    acq_len = 5'd6;
			3'h4:    acq_len = 5'd8;
			3'h5:    acq_len = 5'd12;
			3'h6:    acq_len = 5'd16;
			3'h7:    acq_len = 5'd20;
			default: acq_len = 5'd0;
		endcase
	end

	// Analog pin count: codes up to 0010 make every pin analog
	always @* begin
		if (pcfg_q <= 4'h2) begin
			analog_count = 5'd13;
		end else begin
			analog_count = 5'd15 - {1'b0, pcfg_q};
		end
		for (i = 0; i < `ANALOG_PINS; i = i + 1) begin
			analog_mask[i] = (i < analog_count);
		end
	end

	assign port_read = port_pins_in & ~analog_mask;

	tad_tick_gen #(
		.CNT_W (7)
	) u_tad_tick_gen (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.run     (tad_run),
		.clk_sel (adcs_q),
		.rc_tick (rc_tick),
		.tick    (tick)
	);

	// Control registers
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			on_q   <= 1'b0;
			go_q   <= 1'b0;
			chs_q  <= `CHS_RST;
			acqt_q <= `ACQT_RST;
			adcs_q <= `ADCS_RST;
		end else begin
			if (ctrl0_wr) begin
				on_q  <= wr_data[`CTRL0_ON_BIT];
				chs_q <= wr_data[`CTRL0_CHS_MSB:`CTRL0_CHS_LSB];
				// Start only counts once the converter was already on
				go_q  <= wr_data[`CTRL0_GO_BIT] & wr_data[`CTRL0_ON_BIT] & on_q;
			end else if (conv_end) begin
				go_q <= 1'b0;
			end
			if (ctrl2_wr) begin
				acqt_q <= wr_data[`CTRL2_ACQT_MSB:`CTRL2_ACQT_LSB];
				adcs_q <= wr_data[`CTRL2_ADCS_MSB:`CTRL2_ADCS_LSB];
			end
		end
	end

	// Pin configuration: the strap is caught on the first edge after reset release
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcfg_q       <= `PCFG_RST_ANALOG;
			cfg_loaded_q <= 1'b0;
		end else if (!cfg_loaded_q) begin
			pcfg_q       <= portb_analog_default ? `PCFG_RST_ANALOG : `PCFG_RST_DIGITAL;
			cfg_loaded_q <= 1'b1;
		end else if (ctrl1_wr) begin
			pcfg_q <= wr_data[`CTRL1_PCFG_MSB:`CTRL1_PCFG_LSB];
		end
	end

	// Result registers and done flag; hardware set wins over a software clear
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			res_high_q <= `RESULT_RST;
			res_low_q  <= `RESULT_RST;
			done_q     <= 1'b0;
		end else begin
			if (conv_end) begin
				res_high_q <= {4'h0, sar_q[11:8]};
				res_low_q  <= sar_q[7:0];
			end else begin
				if (wr_stb && addr == `REG_RESULT_HIGH) begin
					res_high_q <= wr_data;
				end
				if (wr_stb && addr == `REG_RESULT_LOW) begin
					res_low_q <= wr_data;
				end
			end
			if (conv_end) begin
				done_q <= 1'b1;
			end else if (wr_stb && addr == `REG_STATUS) begin
				done_q <= wr_data[`STATUS_DONE_BIT];
			end
		end
	end

	// Sequencer: channel select and pin direction play no part here
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'd0;
			sar_q   <= {`RESULT_BITS{1'b0}};
			trial_q <= {`RESULT_BITS{1'b0}};
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 5'd0;
					if (go_q && on_q && !ctrl0_wr) begin
						if (acqt_q != `ACQT_RST) begin
							state_q <= ST_ACQ;
						end else if (rc_sel) begin
							state_q <= ST_RCDLY;
						end else begin
							state_q <= ST_CONV;
							sar_q   <= {`RESULT_BITS{1'b0}};
							trial_q <= TRIAL_MSB;
						end
					end
				end
				ST_ACQ: begin
					// Start flag stays set across this phase and the conversion
					if (abort) begin
						state_q <= ST_WAIT;
						cnt_q   <= 5'd0;
					end else if (tick) begin
						if (cnt_q == acq_len - 5'd1) begin
							state_q <= ST_CONV;
							cnt_q   <= 5'd0;
							sar_q   <= {`RESULT_BITS{1'b0}};
							trial_q <= TRIAL_MSB;
						end else begin
							cnt_q <= cnt_q + 5'd1;
						end
					end
				end
				ST_RCDLY: begin
					if (abort) begin
						state_q <= ST_WAIT;
						cnt_q   <= 5'd0;
					end else if (cnt_q == RCDLY_LAST) begin
						state_q <= ST_CONV;
						cnt_q   <= 5'd0;
						sar_q   <= {`RESULT_BITS{1'b0}};
						trial_q <= TRIAL_MSB;
					end else begin
						cnt_q <= cnt_q + 5'd1;
					end
				end
				ST_CONV: begin
					if (abort) begin
						// Partial code is dropped; result registers are untouched
						state_q <= ST_WAIT;
						cnt_q   <= 5'd0;
					end else if (tick) begin
						if (cnt_q == CONV_LAST) begin
							state_q <= ST_WAIT;
							cnt_q   <= 5'd0;
						end else begin
							if (comp_in) begin
								sar_q <= sar_q | trial_q;
							end
							trial_q <= trial_q >> 1;
							cnt_q   <= cnt_q + 5'd1;
						end
					end
				end
				ST_WAIT: begin
					if (cnt_q == WAIT_LAST) begin
						state_q <= ST_IDLE;
						cnt_q   <= 5'd0;
					end else begin
						cnt_q <= cnt_q + 5'd1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					cnt_q   <= 5'd0;
				end
			endcase
		end
	end

	// Read data appear in the cycle after the strobe; unmapped bits read zero
	always @* begin
		case (addr)
			`REG_CTRL_ZERO:   rd_d = {2'b00, chs_q, go_q, on_q};
			`REG_CTRL_ONE:    rd_d = {4'h0, pcfg_q};
			`REG_CTRL_TWO:    rd_d = {2'b00, acqt_q, adcs_q};
			`REG_RESULT_HIGH: rd_d = res_high_q;
			`REG_RESULT_LOW:  rd_d = res_low_q;
			`REG_STATUS:      rd_d = {7'h00, done_q};
			`REG_PORT_LOW:    rd_d = port_read[7:0];
			`REG_PORT_HIGH:   rd_d = {3'b000, port_read[12:8]};
			default:          rd_d = `RD_DATA_RST;
		endcase
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_q <= `RD_DATA_RST;
		end else if (rd_stb) begin
			rd_data_q <= rd_d;
		end else begin
			rd_data_q <= `RD_DATA_RST;
		end
	end

	// Sampling only while idle or acquiring; opens as soon as conversion is due
	assign hold_capacitor_connect = on_q & ((state_q == ST_IDLE) | (state_q == ST_ACQ));
	assign dac_code               = sar_q | trial_q;
	assign channel_sel            = chs_q;
	assign converter_on           = on_q;
	assign conv_done_irq_flag     = done_q;
	assign rd_data                = rd_data_q;

endmodule // adc_acquire_convert_sequencer

// file: verification/adc_seq_assertions.sv
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
module adc_seq_assertions (
	// Clock and reset
	input wire        sys_clk,
	input wire        sys_rst,
	// Register port
	input wire [2:0]  addr,
	input wire [7:0]  wr_data,
	input wire        wr_stb,
	// Converter outputs
	input wire        hold_capacitor_connect,
	input wire [11:0] dac_code,
	input wire [3:0]  channel_sel,
	input wire        converter_on,
	input wire        conv_done_irq_flag
);
	reg  [5:0] ctrl2_q;
	wire       ctl0_wr = wr_stb && addr == 3'h0;
	wire       stat_wr = wr_stb && addr == 3'h5;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Shadow of the timing fields, so the exact conversion length is known
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl2_q <= 6'h00;
		else if (wr_stb && addr == 3'h2)
			ctrl2_q <= wr_data[5:0];
	end
	sequence s_restart_wait;
		!hold_capacitor_connect [*8] ##1 hold_capacitor_connect;
	endsequence
	sequence s_conv_fast;
		##25 !conv_done_irq_flag ##1 conv_done_irq_flag;
	endsequence
	a_on_bit_write: assert property (ctl0_wr |=> converter_on == $past(wr_data[0]))
		else $error("enable does not follow write");
	a_chan_write: assert property (ctl0_wr |=> channel_sel == $past(wr_data[5:2]))
		else $error("channel does not follow write");
	a_chan_kept: assert property (!ctl0_wr |=> $stable(channel_sel))
		else $error("channel changed without write");
	// A control-zero write that drops sampling is an abort or a turn-off, not a start
	a_conv_start_code: assert property ($fell(hold_capacitor_connect) && ctrl2_q[1:0] != 2'h3
		&& !$past(ctl0_wr) |-> dac_code == 12'h800) else $error("trial code wrong at start");
	a_hold_frozen: assert property ($fell(hold_capacitor_connect) && converter_on
		|-> !hold_capacitor_connect [*8]) else $error("sampling resumed too early");
	a_done_restart: assert property ($rose(conv_done_irq_flag) && !hold_capacitor_connect
		&& !$past(stat_wr) |-> s_restart_wait) else $error("restart wait wrong");
	a_conv_length: assert property ($fell(hold_capacitor_connect) && ctrl2_q == 6'h00
		&& !conv_done_irq_flag |-> s_conv_fast) else $error("conversion length wrong");
	a_done_sticky: assert property (conv_done_irq_flag && !stat_wr |=> conv_done_irq_flag)
		else $error("done flag lost");
	a_done_needs_on: assert property ($rose(conv_done_irq_flag) && !$past(stat_wr)
		|-> converter_on) else $error("done while off");
	a_off_no_sample: assert property (ctl0_wr && !wr_data[0]
		|=> !converter_on && !hold_capacitor_connect) else $error("sampling while off");
endmodule // adc_seq_assertions
bind adc_acquire_convert_sequencer adc_seq_assertions adc_seq_assertions_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
	.hold_capacitor_connect(hold_capacitor_connect), .dac_code(dac_code),
	.channel_sel(channel_sel), .converter_on(converter_on),
	.conv_done_irq_flag(conv_done_irq_flag));

// file: verification/analog_src_model.sv
// Analog source and internal RC clock stand-in for the sequencer bench
`timescale 1ns/1ps
module analog_src_model #(
	parameter int RC_P = 10
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        sys_rst,
	// Converter side
	input  wire [11:0] dac_code,
	input  wire [11:0] target,
	output wire        comp_in,
	output reg         rc_tick
);
	int cnt_q;
	// Level only changes between conversions, so the held value is exact
	assign comp_in = (target >= dac_code);
	// Oscillator runs free, so its phase against a start is arbitrary
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 0;
			rc_tick <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == RC_P - 1) ? 0 : cnt_q + 1;
			rc_tick <= (cnt_q == RC_P - 1);
		end
	end
endmodule // analog_src_model

// file: verification/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
	localparam int RC_P = 10;
	reg         sys_clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg  [2:0]  addr = 3'h0;
	reg  [7:0]  wr_data = 8'h00;
	reg         wr_stb = 1'b0;
	reg         rd_stb = 1'b0;
	reg         strap = 1'b0;
	reg  [12:0] pins = 13'h0000;
	reg  [11:0] target = 12'h000;
	reg         rd_q = 1'b0;
	reg  [3:0]  chn;
	reg  [2:0]  sel;
	reg  [12:0] msk;
	wire [7:0]  rd_data;
	wire        rc_tick, comp_in, hold, on, done;
	wire [11:0] dac_code;
	wire [3:0]  chan;
	logic [7:0] exp_q[$];
	int         n_errors = 0, n_tests = 0, n, m, d, k, a;
	always #12.5 sys_clk = ~sys_clk;
	analog_src_model #(.RC_P(RC_P)) analog_src_model_inst (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .dac_code(dac_code), .target(target), .comp_in(comp_in),
		.rc_tick(rc_tick));
	adc_acquire_convert_sequencer adc_acquire_convert_sequencer_inst (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .portb_analog_default(strap), .rc_tick(rc_tick), .comp_in(comp_in),
		.port_pins_in(pins), .hold_capacitor_connect(hold), .dac_code(dac_code),
		.channel_sel(chan), .converter_on(on), .conv_done_irq_flag(done));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkr(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// A read carries its expected byte; the monitor below compares it
	task bus(input logic w, input logic [2:0] a, input logic [7:0] v);
		wr_stb <= w;
		rd_stb <= ~w;
		addr <= a;
		wr_data <= v;
		if (!w)
			exp_q.push_back(v);
		@(posedge sys_clk);
	endtask
	task cyc(input int c);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		repeat (c) @(posedge sys_clk);
	endtask
	// Cycles until sampling stops, then until the done flag shows
	task spans;
		n = 0;
		m = 0;
		do begin cyc(1); n++; end while (hold !== 1'b0 && n < 5000);
		do begin cyc(1); m++; end while (done !== 1'b1 && m < 5000);
	endtask
	task wrap_up;
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		rd_q <= rd_stb;
		if (rd_q)
			chk("rd_data", exp_q.pop_front(), rd_data);
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'h82161A79));
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cyc(2);
		bus(0, 3'h0, 8'h00);
		bus(0, 3'h1, 8'h07);
		bus(0, 3'h2, 8'h00);
		bus(0, 3'h5, 8'h00);
		bus(1, 3'h0, 8'h03);
		bus(0, 3'h0, 8'h01);
		pins <= $urandom;
		cyc(3 * 64);
		for (k = 0; k < 16; k++) begin
			msk = 13'((1 << ((k <= 2) ? 13 : 15 - k)) - 1);
			bus(1, 3'h1, k[7:0]);
			bus(0, 3'h6, pins[7:0] & ~msk[7:0]);
			bus(0, 3'h7, {3'h0, pins[12:8] & ~msk[12:8]});
		end
		for (k = 0; k < 8; k++) begin
			sel = 3'((k % 6) + ((k % 6) > 2));
			d = 2 << (2 * sel[1:0] + sel[2]);
			a = (k < 5) ? 2 * k : 4 * k - 8;
			chn = $urandom;
			target <= $urandom;
			bus(1, 3'h2, {2'h0, k[2:0], sel});
			bus(1, 3'h5, 8'h00);
			bus(1, 3'h0, {2'h0, chn, 2'h3});
			spans;
			chkr("acq span", 2 + a * d, 3 + a * d, n);
			chk("conv span", 13 * d, m);
			bus(0, 3'h0, {2'h0, chn, 2'h1});
			bus(0, 3'h3, {4'h0, target[11:8]});
			bus(0, 3'h4, target[7:0]);
			bus(0, 3'h5, 8'h01);
			chk("channel", chn, chan);
			cyc(10);
		end
		for (k = 0; k < 2; k++) begin
			bus(1, 3'h5, 8'h00);
			bus(1, 3'h2, {5'h00, k[0], 2'h3});
			bus(1, 3'h0, 8'h03);
			spans;
			chkr("rc span", 12 * RC_P + 4, 13 * RC_P + 5, m);
			cyc(10);
		end
		bus(1, 3'h5, 8'h00);
		bus(1, 3'h2, 8'h02);
		bus(1, 3'h0, 8'h03);
		cyc(30);
		bus(0, 3'h0, 8'h03);
		bus(1, 3'h0, 8'h01);
		cyc(12);
		chk("abort done", 1'b0, done);
		chk("abort hold", 1'b1, hold);
		bus(0, 3'h3, {4'h0, target[11:8]});
		bus(0, 3'h4, target[7:0]);
		chn = $urandom;
		bus(1, 3'h4, {4'h0, chn});
		bus(0, 3'h4, {4'h0, chn});
		bus(1, 3'h0, 8'h00);
		bus(0, 3'h0, 8'h00);
		bus(1, 3'h0, 8'h01);
		cyc(3 * 32);
		bus(1, 3'h0, 8'h03);
		strap <= 1'b1;
		cyc(20);
		sys_rst <= 1'b1;
		cyc(2);
		chk("reset on", 1'b0, on);
		sys_rst <= 1'b0;
		cyc(2);
		bus(0, 3'h0, 8'h00);
		bus(0, 3'h1, 8'h00);
		bus(0, 3'h4, 8'h00);
		cyc(3);
		wrap_up;
	end
endmodule // testbench
